// File: verilog/vic_regs.svh
// Register map, field positions, the auto-clear default and timing counts of the interrupt controller.
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

`define VIC_OFS_MAIN_EN 8'h00
`define VIC_OFS_EXT_EN 8'h04
`define VIC_OFS_PRIO 8'h08
`define VIC_OFS_PEND 8'h0c
`define VIC_OFS_PEND_SET 8'h10
`define VIC_OFS_PEND_CLR 8'h14
`define VIC_OFS_STATUS 8'h18

`define VIC_GLOBAL_BIT 7
`define VIC_MAIN_SRC 7
`define VIC_NUM_SRC 18
`define VIC_AUTO_CLR_DEF 18'h1000f
`define VIC_ZERO32 32'h0000_0000

`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_SHIFT 3

`define VIC_CALL_CYCLES 3'h4
`define VIC_CNT_ONE 3'h1

`define VIC_STAT_LOW_BIT 0
`define VIC_STAT_HIGH_BIT 1
`define VIC_STAT_CALL_BIT 2
`define VIC_STAT_IDX_LSB 8

`endif

// File: verilog/vic_pkg.sv
// Types shared by the interrupt controller modules.
package vic_pkg;

	typedef enum logic [0:0]
	{
		VIC_IDLE = 1'b0,
		VIC_CALL = 1'b1
	} vic_state_e;

	typedef logic [15:0] vic_addr_t;

endpackage

// File: verilog/vic_prio_enc.sv
// Fixed-order priority encoder: the lowest requesting index wins.
`timescale 1ns/1ns
module vic_prio_enc #(
	parameter int N = 18,
	parameter int IW = 5
)
(
	// Requests.
	input wire logic [N-1:0] req,
	// Winner.
	output logic valid,
	output logic [IW-1:0] idx
);

	always_comb
	begin
		valid = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				valid = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule // vic_prio_enc

// File: verilog/vic_top.sv
// Vectored interrupt controller with APB registers and a core-side call interface.
`timescale 1ns/1ns
`include "vic_regs.svh"

module vic_top
	import vic_pkg::*;
#(
	parameter int NUM_SRC = `VIC_NUM_SRC,
	parameter int ADDR_W = 8,
	parameter logic [NUM_SRC-1:0] AUTO_CLR = `VIC_AUTO_CLR_DEF
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral sources.
	input wire logic [NUM_SRC-1:0] srcEvent,
	// Processor core.
	input wire logic insnDone,
	input wire logic insnSingle,
	input wire logic retiDone,
	output logic irqReq,
	output logic irqCall,
	output vic_addr_t irqVector
);

	localparam int IW = $clog2(NUM_SRC);
	localparam int EXT_W = NUM_SRC - `VIC_MAIN_SRC;

	// ----------------------------------------------------------------
	// Parameter check.
	// ----------------------------------------------------------------
	generate
		if (NUM_SRC <= `VIC_MAIN_SRC || NUM_SRC > 32 || ADDR_W < 8)
		begin : gBadParam
			$error("vic_top parameters out of range");
		end
	endgenerate

	function automatic vic_addr_t vecAddr(input logic [IW-1:0] idx);
		vecAddr = 16'(`VIC_VEC_BASE + (16'(idx) << `VIC_VEC_SHIFT));
	endfunction

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic [7:0] enMain_q;
	logic [EXT_W-1:0] enExt_q;
	logic [NUM_SRC-1:0] prio_q;
	logic [NUM_SRC-1:0] pend_q;
	logic [NUM_SRC-1:0] pend_d;
	logic [NUM_SRC-1:0] pendSeen_q;
	logic [NUM_SRC-1:0] enSnap_q;
	logic inLow_q;
	logic inHigh_q;
	vic_state_e state_q;
	logic [2:0] cnt_q;
	logic [IW-1:0] curIdx_q;
	logic curHigh_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irqReq_q;
	logic irqCall_q;
	vic_addr_t irqVector_q;

	// ----------------------------------------------------------------
	// APB decode.
	// ----------------------------------------------------------------
	wire apbSetup = psel & penable & ~pready_q;
	wire apbAcc = psel & penable & pready_q;
	wire apbWr = apbAcc & pwrite;
	wire [7:0] ofs = paddr[7:0];
	wire upperZero = (ADDR_W == 8) ? 1'b1 : (paddr >> 8) == '0;
	wire selMain = upperZero & (ofs == `VIC_OFS_MAIN_EN);
	wire selExt = upperZero & (ofs == `VIC_OFS_EXT_EN);
	wire selPrio = upperZero & (ofs == `VIC_OFS_PRIO);
	wire selPend = upperZero & (ofs == `VIC_OFS_PEND);
	wire selSet = upperZero & (ofs == `VIC_OFS_PEND_SET);
	wire selClr = upperZero & (ofs == `VIC_OFS_PEND_CLR);
	wire selStat = upperZero & (ofs == `VIC_OFS_STATUS);
	wire selAny = selMain | selExt | selPrio | selPend | selSet | selClr | selStat;

	wire [31:0] statWord = `VIC_ZERO32
		| (32'(inLow_q) << `VIC_STAT_LOW_BIT)
		| (32'(inHigh_q) << `VIC_STAT_HIGH_BIT)
		| (32'(state_q == VIC_CALL) << `VIC_STAT_CALL_BIT)
		| (32'(curIdx_q) << `VIC_STAT_IDX_LSB);

	logic [31:0] rdMux;
	always_comb
	begin
		if (selMain)
			rdMux = 32'(enMain_q);
		else if (selExt)
			rdMux = 32'(enExt_q);
		else if (selPrio)
			rdMux = 32'(prio_q);
		else if (selPend)
			rdMux = 32'(pend_q);
		else if (selStat)
			rdMux = statWord;
		else
			rdMux = `VIC_ZERO32;
	end

	// ----------------------------------------------------------------
	// Enables, priorities and pending flags.
	// ----------------------------------------------------------------
	wire [NUM_SRC-1:0] indEn = {enExt_q, enMain_q[`VIC_MAIN_SRC-1:0]};
	wire globEn = enMain_q[`VIC_GLOBAL_BIT];
	wire [NUM_SRC-1:0] effEn = indEn & {NUM_SRC{globEn}};
	wire [NUM_SRC-1:0] lateEn = enSnap_q & {NUM_SRC{insnSingle}};
	wire [NUM_SRC-1:0] useEn = effEn | lateEn;
	wire [NUM_SRC-1:0] cand = pendSeen_q & pend_q & useEn;
	wire [NUM_SRC-1:0] candHi = cand & prio_q;
	wire [NUM_SRC-1:0] candLo = cand & ~prio_q;

	wire hiValid;
	wire loValid;
	wire [IW-1:0] hiIdx;
	wire [IW-1:0] loIdx;

	vic_prio_enc #(
		.N(NUM_SRC),
		.IW(IW)
	) uEncHi (
		.req(candHi),
		.valid(hiValid),
		.idx(hiIdx)
	);

	vic_prio_enc #(
		.N(NUM_SRC),
		.IW(IW)
	) uEncLo (
		.req(candLo),
		.valid(loValid),
		.idx(loIdx)
	);

	// ----------------------------------------------------------------
	// Acceptance.
	// ----------------------------------------------------------------
	wire hiOk = hiValid & ~inHigh_q;
	wire loOk = loValid & ~inHigh_q & ~inLow_q;
	wire boundary = insnDone & ~retiDone & (state_q == VIC_IDLE);
	wire takeNow = boundary & (hiOk | loOk);
	wire takeHigh = hiOk;
	wire [IW-1:0] takeIdx = takeHigh ? hiIdx : loIdx;
	wire [NUM_SRC-1:0] takeOne = NUM_SRC'(1) << takeIdx;
	wire [NUM_SRC-1:0] autoClr = takeNow ? (takeOne & AUTO_CLR) : '0;
	wire [NUM_SRC-1:0] swSet = (apbWr & selSet) ? pwdata[NUM_SRC-1:0] : '0;
	wire [NUM_SRC-1:0] swClr = (apbWr & selClr) ? pwdata[NUM_SRC-1:0] : '0;
	wire callEnd = (state_q == VIC_CALL) & (cnt_q == `VIC_CNT_ONE);

	always_comb
	begin
		pend_d = (pend_q & ~(swClr | autoClr)) | srcEvent | swSet;
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enMain_q <= '0;
			enExt_q <= '0;
			prio_q <= '0;
		end
		else if (apbWr)
		begin
			if (selMain)
				enMain_q <= pwdata[7:0];
			if (selExt)
				enExt_q <= pwdata[EXT_W-1:0];
			if (selPrio)
				prio_q <= pwdata[NUM_SRC-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_q <= '0;
			pendSeen_q <= '0;
			enSnap_q <= '0;
		end
		else
		begin
			pend_q <= pend_d;
			pendSeen_q <= pend_q;
			if (insnDone)
				enSnap_q <= effEn;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			inLow_q <= 1'b0;
			inHigh_q <= 1'b0;
		end
		else if (callEnd)
		begin
			if (curHigh_q)
				inHigh_q <= 1'b1;
			else
				inLow_q <= 1'b1;
		end
		else if (retiDone)
		begin
			if (inHigh_q)
				inHigh_q <= 1'b0;
			else
				inLow_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= VIC_IDLE;
			cnt_q <= '0;
			curIdx_q <= '0;
			curHigh_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				VIC_IDLE:
				begin
					if (takeNow)
					begin
						state_q <= VIC_CALL;
						cnt_q <= `VIC_CALL_CYCLES;
						curIdx_q <= takeIdx;
						curHigh_q <= takeHigh;
					end
				end
				VIC_CALL:
				begin
					cnt_q <= cnt_q - `VIC_CNT_ONE;
					if (callEnd)
						state_q <= VIC_IDLE;
				end
				default:
					state_q <= VIC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irqReq_q <= 1'b0;
			irqCall_q <= 1'b0;
			irqVector_q <= '0;
		end
		else
		begin
			irqReq_q <= |(pend_q & effEn);
			if (takeNow)
			begin
				irqCall_q <= 1'b1;
				irqVector_q <= vecAddr(takeIdx);
			end
			else if (callEnd)
				irqCall_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= apbSetup;
			if (apbSetup)
			begin
				prdata_q <= pwrite ? `VIC_ZERO32 : rdMux;
				pslverr_q <= ~selAny;
			end
			else
			begin
				prdata_q <= `VIC_ZERO32;
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irqReq = irqReq_q;
	assign irqCall = irqCall_q;
	assign irqVector = irqVector_q;

endmodule // vic_top

// File: testbench/vic_top_sva.sv
// Port checker of the interrupt controller.
`timescale 1ns/1ns
module vic_top_sva
	import vic_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Core.
	input wire logic insnDone,
	input wire logic retiDone,
	input wire logic irqCall,
	input wire vic_addr_t irqVector
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	AST_CALL_LEN: assert property ($rose(irqCall) |-> irqCall [*4] ##1 !irqCall)
		else $error("call length wrong");
	AST_CALL_AT_BOUNDARY: assert property ($rose(irqCall) |-> $past(insnDone))
		else $error("call without boundary");
	AST_NO_TAKE_AT_RETURN_FROM_IRQ_INSN: assert property (insnDone && retiDone && !irqCall |=> !irqCall)
		else $error("call at return boundary");
	AST_VEC_FORM: assert property ($rose(irqCall) |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h008b)
		else $error("vector malformed");
	AST_VEC_HOLD: assert property (irqCall && $past(irqCall) |-> $stable(irqVector))
		else $error("vector moved");
	AST_READY_WAIT: assert property (psel && $rose(penable) |=> pready)
		else $error("ready late");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready too long");
	AST_RDATA_QUIET: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");
	cover property ($rose(irqCall));
	cover property (insnDone && retiDone);
	cover property (pready);
endmodule // vic_top_sva

bind vic_top vic_top_sva vic_top_sva_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .insnDone(insnDone), .retiDone(retiDone),
	.irqCall(irqCall), .irqVector(irqVector));

// File: testbench/vic_core_model.sv
// Behavioural model of the processor core at the call interface.
`timescale 1ns/1ns
module vic_core_model
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Bench commands.
	input wire logic doReti,
	input wire logic single,
	// Controller side.
	input wire logic irqCall,
	output logic insnDone,
	output logic insnSingle,
	output logic retiDone
);
	logic done_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			done_q <= 1'b0;
		else
			done_q <= !done_q && !irqCall;
	end
	assign insnDone = done_q;
	assign insnSingle = done_q & single;
	assign retiDone = done_q & doReti;
endmodule // vic_core_model

// File: testbench/vic_top_tb_top.sv
// Self-checking bench of the interrupt controller.
`timescale 1ns/1ns
`include "vic_regs.svh"
module vic_top_tb_top
	import vic_pkg::*;
;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, slv;
	logic insnDone, insnSingle, retiDone, irqReq, irqCall, doReti, single;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [17:0] srcEvent;
	vic_addr_t irqVector;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int lat;
	vic_top vic_top_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .srcEvent(srcEvent), .insnDone(insnDone), .insnSingle(insnSingle),
		.retiDone(retiDone), .irqReq(irqReq), .irqCall(irqCall), .irqVector(irqVector));
	vic_core_model vic_core_model_inst (.clk(clk), .nrst(nrst), .doReti(doReti),
		.single(single), .irqCall(irqCall), .insnDone(insnDone), .insnSingle(insnSingle),
		.retiDone(retiDone));
	always #5 clk = ~clk;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			give_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic return_from_irq_insn();
		@(posedge clk);
		doReti <= 1'b1;
		do @(posedge clk); while (insnDone !== 1'b1);
		doReti <= 1'b0;
	endtask
	task automatic waitCall(input logic [15:0] v, output int n);
		n = 0;
		while (n < 60 && irqCall !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		check(irqVector, 32'(v));
	endtask
	task automatic lateClear();
		do @(posedge clk); while (insnDone !== 1'b1);
		fork
			apb(1'b1, `VIC_OFS_MAIN_EN, 32'h80);
			begin
				do @(posedge clk); while (psel !== 1'b1 || penable !== 1'b1);
				srcEvent <= 18'h00010;
				@(posedge clk);
				srcEvent <= 18'h0;
			end
		join
	endtask
	initial
	begin
		clk = 0;
		nrst = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		srcEvent = 0;
		doReti = 0;
		single = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rdc(`VIC_OFS_MAIN_EN, 32'h0);
		rdc(`VIC_OFS_PRIO, 32'h0);
		rdc(`VIC_OFS_STATUS, 32'h0);
		rdc(8'h1c, 32'h0);
		check(32'(slv), 32'h1);
		srcEvent <= 18'h00020;
		@(posedge clk);
		srcEvent <= 18'h0;
		rdc(`VIC_OFS_PEND, 32'h20);
		check(32'(irqReq), 32'h0);
		apb(1'b1, `VIC_OFS_MAIN_EN, 32'h20);
		repeat (4) @(posedge clk);
		check(32'(irqReq | irqCall), 32'h0);
		apb(1'b1, `VIC_OFS_MAIN_EN, 32'ha0);
		waitCall(16'h002b, lat);
		check(32'(irqReq), 32'h1);
		repeat (6) @(posedge clk);
		rdc(`VIC_OFS_STATUS, 32'h501);
		rdc(`VIC_OFS_PEND, 32'h20);
		return_from_irq_insn();
		waitCall(16'h002b, lat);
		check(32'(lat), 32'h3);
		repeat (6) @(posedge clk);
		apb(1'b1, `VIC_OFS_PEND_CLR, 32'h20);
		return_from_irq_insn();
		repeat (8) @(posedge clk);
		check(32'(irqCall), 32'h0);
		apb(1'b0, `VIC_OFS_STATUS, 32'h0);
		check(rd & 32'h7, 32'h0);
		apb(1'b1, `VIC_OFS_PRIO, 32'h200);
		apb(1'b1, `VIC_OFS_EXT_EN, 32'h4);
		apb(1'b1, `VIC_OFS_MAIN_EN, 32'h88);
		apb(1'b1, `VIC_OFS_PEND_SET, 32'h208);
		waitCall(16'h004b, lat);
		repeat (12) @(posedge clk);
		rdc(`VIC_OFS_STATUS, 32'h902);
		apb(1'b1, `VIC_OFS_PEND_CLR, 32'h200);
		return_from_irq_insn();
		waitCall(16'h001b, lat);
		check(32'(lat), 32'h3);
		rdc(`VIC_OFS_PEND, 32'h0);
		return_from_irq_insn();
		single <= 1'b1;
		apb(1'b1, `VIC_OFS_MAIN_EN, 32'h90);
		lateClear();
		waitCall(16'h0023, lat);
		rdc(`VIC_OFS_MAIN_EN, 32'h80);
		apb(1'b1, `VIC_OFS_PEND_CLR, 32'h10);
		return_from_irq_insn();
		single <= 1'b0;
		apb(1'b1, `VIC_OFS_MAIN_EN, 32'h90);
		lateClear();
		repeat (10) @(posedge clk);
		check(32'(irqCall), 32'h0);
		rdc(`VIC_OFS_PEND, 32'h10);
		give_verdict();
	end
endmodule // vic_top_tb_top
